// [logic/fxu_pkg.sv]
package fxu_pkg;

	// Flag bit positions
	localparam int unsigned BIT_CARRY = 0;
	localparam int unsigned BIT_RSVD_ONE = 1;
	localparam int unsigned BIT_PARITY = 2;
	localparam int unsigned BIT_HALF_CARRY = 4;
	localparam int unsigned BIT_ZERO = 6;
	localparam int unsigned BIT_SIGN = 7;
	localparam int unsigned BIT_IRQ_EN = 9;
	localparam int unsigned BIT_DIR = 10;
	localparam int unsigned BIT_IO_PRIV_LO = 12;
	localparam int unsigned BIT_IO_PRIV_HI = 13;
	localparam int unsigned BIT_RESUME = 16;
	localparam int unsigned BIT_V86 = 17;
	localparam int unsigned BIT_ALIGN_CHK = 18;
	localparam int unsigned BIT_PROBE = 21;

	// Flag masks and reset value
	localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
	localparam logic [31:0] POP_WORD_MASK = 32'h0000_0DD5;
	localparam logic [31:0] POP_DWORD_EXTRA = 32'h0024_0000;
	localparam logic [31:0] IO_PRIV_MASK = 32'h0000_3000;
	localparam logic [31:0] IRQ_EN_MASK = 32'h0000_0200;
	localparam logic [31:0] PUSH_CLEAR_MASK = 32'h0003_0000;

	// Register map, byte addresses
	localparam int unsigned AXI_ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FLAGS = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int unsigned CTRL_ACC_HI_OK = 0;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_FAULT = 1;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// Stack access sizes
	localparam logic [1:0] SZ_WORD = 2'h0;
	localparam logic [1:0] SZ_DWORD = 2'h1;
	localparam logic [1:0] SZ_QWORD = 2'h2;

	typedef enum logic [3:0] {
		OP_FLAGS_TO_ACC_HI,
		OP_ACC_HI_TO_FLAGS,
		OP_PUSH_WORD,
		OP_PUSH_DWORD,
		OP_POP_WORD,
		OP_POP_DWORD,
		OP_SET_IRQ_EN,
		OP_CLR_IRQ_EN,
		OP_SET_DIR,
		OP_CLR_DIR
	} fxu_op_e;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PUSH,
		ST_POP_REQ,
		ST_POP_WAIT
	} fxu_state_e;

	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_CTRL,
		SEL_FLAGS,
		SEL_STATUS
	} fxu_sel_e;

	typedef struct packed {
		fxu_state_e st;
		logic [31:0] flags;
		logic [7:0] acc_hi;
		logic stk_write;
		logic [1:0] stk_size;
		logic [63:0] stk_data;
		logic done;
		logic fault;
		logic last_fault;
		logic acc_hi_ok;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fxu_state_s;

	// Status flags into the accumulator high byte, bit for bit
	function automatic logic [7:0] fxu_acc_hi_pack(input logic [31:0] f);
		fxu_acc_hi_pack = {f[BIT_SIGN], f[BIT_ZERO], 1'b0, f[BIT_HALF_CARRY], 1'b0,
			f[BIT_PARITY], 1'b0, f[BIT_CARRY]};
	endfunction : fxu_acc_hi_pack

	// Register select from a byte address
	function automatic fxu_sel_e fxu_reg_sel(input logic [AXI_ADDR_W-1:0] a);
		logic [7:0] w;
		w = {a[AXI_ADDR_W-1:2], 2'b00};
		if (w == REG_CTRL)
			fxu_reg_sel = SEL_CTRL;
		else if (w == REG_FLAGS)
			fxu_reg_sel = SEL_FLAGS;
		else if (w == REG_STATUS)
			fxu_reg_sel = SEL_STATUS;
		else
			fxu_reg_sel = SEL_NONE;
	endfunction : fxu_reg_sel

endpackage : fxu_pkg

// [logic/fxu_pop_if.sv]
`timescale 1ns/10ps
interface fxu_pop_if;
	logic [31:0] old_flags;
	logic [31:0] pop_data;
	logic [1:0] priv_level;
	logic dword;
	logic [31:0] new_flags;

	modport calc (
		input old_flags,
		input pop_data,
		input priv_level,
		input dword,
		output new_flags
	);

	modport user (
		output old_flags,
		output pop_data,
		output priv_level,
		output dword,
		input new_flags
	);
endinterface : fxu_pop_if

// [logic/fxu_pop_merge.sv]
`timescale 1ns/10ps
module fxu_pop_merge
	import fxu_pkg::*;
(
	fxu_pop_if.calc pm
);
	logic [31:0] mask;

	always_comb
	begin
		mask = POP_WORD_MASK; // [RULE6]
		if (pm.dword)
			mask = mask | POP_DWORD_EXTRA; // [RULE9]
		if (pm.priv_level == 2'h0)
			mask = mask | IO_PRIV_MASK; // [RULE7] [RULE10]
		if (pm.old_flags[BIT_IO_PRIV_HI:BIT_IO_PRIV_LO] >= pm.priv_level)
			mask = mask | IRQ_EN_MASK; // [RULE8] [RULE10]
	end

	// Unmasked bits keep their value
	assign pm.new_flags = (pm.old_flags & ~mask) | (pm.pop_data & mask); // [RULE19]
endmodule : fxu_pop_merge

// [logic/fxu_top.sv]
// Function
// RULE1: Flags-to-accumulator-high copies sign, zero, half-carry, parity, carry to bits 7,6,4,2,0.
// RULE2: That copy leaves bits 5,3,1 undefined and leaves the flags untouched.
// RULE3: Accumulator-high-to-flags loads those five flags from bits 7,6,4,2,0.
// RULE4: Word push of flags pushes only the low 16 flag bits.
// RULE5: Doubleword push pushes all 32 flag bits with resume and virtual-8086 cleared.
// RULE6: Word pop updates only bits 11,10,8,7,6,4,2,0 from the popped word.
// RULE7: Pops update the I/O privilege field only at privilege level 0.
// RULE8: Pops update interrupt enable only when I/O privilege is at least privilege level.
// RULE9: Doubleword pop may also update alignment-check bit 18 and probe bit 21.
// RULE10: Doubleword pop applies the same privilege guards as the word pop.
// RULE11: Maskable interrupt requests are serviced while interrupt enable is set, masked otherwise.
// RULE12: Set and clear interrupt-enable operations write the flag to one and zero.
// RULE13: Interrupt-enable set and clear are permitted only as mode and privilege allow.
// RULE14: In 64-bit mode the accumulator-high transfers need the capability bit set.
// RULE15: Word push and pop behave alike inside and outside 64-bit mode.
// RULE16: In 64-bit mode doubleword push pushes 64 bits, resume and virtual-8086 cleared.
// RULE17: In 64-bit mode doubleword pop pops 64 bits, loads low half, upper bits zero.
// RULE18: Direction set and clear write the flag; indexes step up when clear, down when set.
// RULE19: Flag bits a pop may not change keep their previous value.
// RULE20: The five status flags live at flag bits 7,6,4,2,0.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module fxu_top
	import fxu_pkg::*;
#(
	parameter bit ACC_HI_64_RESET = 1'b1
)
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire logic op_valid_in,
	output logic op_ready_out,
	input wire fxu_op_e op_in,
	input wire logic mode64_in,
	input wire logic prot_mode_in,
	input wire logic [1:0] priv_level_in,
	input wire logic [7:0] acc_hi_in,
	output logic [7:0] acc_hi_out,
	output logic done_out,
	output logic fault_out,
	output logic stk_req_valid_out,
	input wire logic stk_req_ready_in,
	output logic stk_req_write_out,
	output logic [1:0] stk_req_size_out,
	output logic [63:0] stk_req_data_out,
	input wire logic stk_rsp_valid_in,
	input wire logic [63:0] stk_rsp_data_in,
	output logic [63:0] flags_out,
	input wire logic maskable_irq_pin_in,
	output logic irq_service_out,
	output logic index_step_down_out,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam fxu_state_s RESET_STATE = '{
		st: ST_IDLE,
		flags: FLAGS_RESET,
		acc_hi: 8'h00,
		stk_write: 1'b0,
		stk_size: SZ_WORD,
		stk_data: 64'h0000_0000_0000_0000,
		done: 1'b0,
		fault: 1'b0,
		last_fault: 1'b0,
		acc_hi_ok: ACC_HI_64_RESET,
		bvalid: 1'b0,
		bresp: AXI_OKAY,
		rvalid: 1'b0,
		rdata: 32'h0000_0000,
		rresp: AXI_OKAY
	};

	fxu_state_s cur_ff;
	fxu_state_s nxt_cur;
	logic op_take;
	logic acc_ok;
	logic irq_ok;
	logic wr_take;
	logic rd_take;
	logic [31:0] push_img;
	fxu_sel_e wr_sel;
	fxu_sel_e rd_sel;

	fxu_pop_if pop_bus ();

	fxu_pop_merge u_pop_merge (
		.pm(pop_bus)
	);

	assign pop_bus.old_flags = cur_ff.flags;
	assign pop_bus.pop_data = stk_rsp_data_in[31:0]; // [RULE17]
	assign pop_bus.priv_level = priv_level_in;
	assign pop_bus.dword = (cur_ff.stk_size != SZ_WORD);

	// Issue handshake
	assign op_ready_out = clk_en_in && (cur_ff.st == ST_IDLE);
	assign op_take = op_valid_in && op_ready_out;
	assign acc_ok = !mode64_in || cur_ff.acc_hi_ok; // [RULE14]
	assign irq_ok = !prot_mode_in
		|| (priv_level_in <= cur_ff.flags[BIT_IO_PRIV_HI:BIT_IO_PRIV_LO]); // [RULE13]
	assign push_img = cur_ff.flags & ~PUSH_CLEAR_MASK; // [RULE5] [RULE16]

	// Register bus handshakes
	assign wr_take = clk_en_in && s_axi_awvalid && s_axi_wvalid && !cur_ff.bvalid;
	assign rd_take = clk_en_in && s_axi_arvalid && !cur_ff.rvalid;
	assign wr_sel = fxu_reg_sel(s_axi_awaddr);
	assign rd_sel = fxu_reg_sel(s_axi_araddr);

	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_cur.done = 1'b0;
		nxt_cur.fault = 1'b0;
		unique case (cur_ff.st)
			ST_IDLE:
			begin
				if (op_take)
				begin
					nxt_cur.done = 1'b1;
					case (op_in)
						OP_FLAGS_TO_ACC_HI:
						begin
							if (acc_ok)
								nxt_cur.acc_hi = fxu_acc_hi_pack(cur_ff.flags); // [RULE1] [RULE2]
							else
								nxt_cur.fault = 1'b1; // [RULE14]
						end
						OP_ACC_HI_TO_FLAGS:
						begin
							if (acc_ok)
							begin
								nxt_cur.flags[BIT_SIGN] = acc_hi_in[7]; // [RULE3] [RULE20]
								nxt_cur.flags[BIT_ZERO] = acc_hi_in[6];
								nxt_cur.flags[BIT_HALF_CARRY] = acc_hi_in[4];
								nxt_cur.flags[BIT_PARITY] = acc_hi_in[2];
								nxt_cur.flags[BIT_CARRY] = acc_hi_in[0];
							end
							else
								nxt_cur.fault = 1'b1; // [RULE14]
						end
						OP_PUSH_WORD:
						begin
							nxt_cur.done = 1'b0;
							nxt_cur.st = ST_PUSH;
							nxt_cur.stk_write = 1'b1;
							nxt_cur.stk_size = SZ_WORD; // [RULE15]
							nxt_cur.stk_data = {48'h0000_0000_0000, cur_ff.flags[15:0]}; // [RULE4]
						end
						OP_PUSH_DWORD:
						begin
							nxt_cur.done = 1'b0;
							nxt_cur.st = ST_PUSH;
							nxt_cur.stk_write = 1'b1;
							nxt_cur.stk_size = mode64_in ? SZ_QWORD : SZ_DWORD; // [RULE16]
							nxt_cur.stk_data = {32'h0000_0000, push_img}; // [RULE5]
						end
						OP_POP_WORD:
						begin
							nxt_cur.done = 1'b0;
							nxt_cur.st = ST_POP_REQ;
							nxt_cur.stk_write = 1'b0;
							nxt_cur.stk_size = SZ_WORD; // [RULE15]
						end
						OP_POP_DWORD:
						begin
							nxt_cur.done = 1'b0;
							nxt_cur.st = ST_POP_REQ;
							nxt_cur.stk_write = 1'b0;
							nxt_cur.stk_size = mode64_in ? SZ_QWORD : SZ_DWORD; // [RULE17]
						end
						OP_SET_IRQ_EN:
						begin
							if (irq_ok)
								nxt_cur.flags[BIT_IRQ_EN] = 1'b1; // [RULE12]
							else
								nxt_cur.fault = 1'b1; // [RULE13]
						end
						OP_CLR_IRQ_EN:
						begin
							if (irq_ok)
								nxt_cur.flags[BIT_IRQ_EN] = 1'b0; // [RULE12]
							else
								nxt_cur.fault = 1'b1; // [RULE13]
						end
						OP_SET_DIR:
							nxt_cur.flags[BIT_DIR] = 1'b1; // [RULE18]
						OP_CLR_DIR:
							nxt_cur.flags[BIT_DIR] = 1'b0; // [RULE18]
						default:
							nxt_cur.fault = 1'b1;
					endcase
				end
			end
			ST_PUSH:
			begin
				if (stk_req_ready_in)
				begin
					nxt_cur.st = ST_IDLE;
					nxt_cur.done = 1'b1;
				end
			end
			ST_POP_REQ:
			begin
				if (stk_req_ready_in)
					nxt_cur.st = ST_POP_WAIT;
			end
			ST_POP_WAIT:
			begin
				if (stk_rsp_valid_in)
				begin
					nxt_cur.flags = pop_bus.new_flags; // [RULE6] [RULE9] [RULE19]
					nxt_cur.flags[BIT_RSVD_ONE] = 1'b1;
					nxt_cur.st = ST_IDLE;
					nxt_cur.done = 1'b1;
				end
			end
		endcase
		if (nxt_cur.fault)
			nxt_cur.last_fault = 1'b1;
		// Register writes
		if (wr_take)
		begin
			nxt_cur.bvalid = 1'b1;
			nxt_cur.bresp = (wr_sel == SEL_NONE) ? AXI_SLVERR : AXI_OKAY;
			if (wr_sel == SEL_CTRL && s_axi_wstrb[0])
				nxt_cur.acc_hi_ok = s_axi_wdata[CTRL_ACC_HI_OK]; // [RULE14]
			if (wr_sel == SEL_STATUS && s_axi_wstrb[0] && s_axi_wdata[STAT_FAULT]
				&& !nxt_cur.fault)
				nxt_cur.last_fault = 1'b0;
		end
		else if (cur_ff.bvalid && s_axi_bready)
			nxt_cur.bvalid = 1'b0;
		// Register reads
		if (rd_take)
		begin
			nxt_cur.rvalid = 1'b1;
			nxt_cur.rresp = AXI_OKAY;
			nxt_cur.rdata = 32'h0000_0000;
			unique case (rd_sel)
				SEL_CTRL:
					nxt_cur.rdata[CTRL_ACC_HI_OK] = cur_ff.acc_hi_ok;
				SEL_FLAGS:
					nxt_cur.rdata = cur_ff.flags;
				SEL_STATUS:
				begin
					nxt_cur.rdata[STAT_BUSY] = (cur_ff.st != ST_IDLE);
					nxt_cur.rdata[STAT_FAULT] = cur_ff.last_fault;
				end
				SEL_NONE:
					nxt_cur.rresp = AXI_SLVERR;
			endcase
		end
		else if (cur_ff.rvalid && s_axi_rready)
			nxt_cur.rvalid = 1'b0;
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			cur_ff <= RESET_STATE;
		else if (clk_en_in)
			cur_ff <= nxt_cur;
	end

	// Outputs
	assign acc_hi_out = cur_ff.acc_hi;
	assign done_out = cur_ff.done;
	assign fault_out = cur_ff.fault;
	assign stk_req_valid_out = (cur_ff.st == ST_PUSH) || (cur_ff.st == ST_POP_REQ);
	assign stk_req_write_out = cur_ff.stk_write;
	assign stk_req_size_out = cur_ff.stk_size;
	assign stk_req_data_out = cur_ff.stk_data;
	assign flags_out = {32'h0000_0000, cur_ff.flags}; // [RULE17]
	assign irq_service_out = maskable_irq_pin_in && cur_ff.flags[BIT_IRQ_EN]; // [RULE11]
	assign index_step_down_out = cur_ff.flags[BIT_DIR]; // [RULE18]
	assign s_axi_awready = wr_take;
	assign s_axi_wready = wr_take;
	assign s_axi_bvalid = cur_ff.bvalid;
	assign s_axi_bresp = cur_ff.bresp;
	assign s_axi_arready = rd_take;
	assign s_axi_rvalid = cur_ff.rvalid;
	assign s_axi_rdata = cur_ff.rdata;
	assign s_axi_rresp = cur_ff.rresp;

	// Checks
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	sequence s_take(fxu_op_e o);
		op_take && op_in == o;
	endsequence

	sequence s_pop_end;
		clk_en_in && cur_ff.st == ST_POP_WAIT && stk_rsp_valid_in;
	endsequence

	a_acc_hi_copy: assert property (s_take(OP_FLAGS_TO_ACC_HI) and acc_ok |=> // [RULE1]
		acc_hi_out[7] == $past(cur_ff.flags[7]) && acc_hi_out[6] == $past(cur_ff.flags[6])
		&& acc_hi_out[4] == $past(cur_ff.flags[4]) && acc_hi_out[2] == $past(cur_ff.flags[2])
		&& acc_hi_out[0] == $past(cur_ff.flags[0]) && done_out)
		else $error("accumulator high byte copy wrong");

	a_acc_hi_keep: assert property (s_take(OP_FLAGS_TO_ACC_HI) |=> // [RULE2]
		$stable(cur_ff.flags))
		else $error("flags changed by copy to accumulator");

	a_acc_hi_load: assert property (s_take(OP_ACC_HI_TO_FLAGS) and acc_ok |=> // [RULE3]
		cur_ff.flags[7] == $past(acc_hi_in[7]) && cur_ff.flags[6] == $past(acc_hi_in[6])
		&& cur_ff.flags[4] == $past(acc_hi_in[4]) && cur_ff.flags[2] == $past(acc_hi_in[2])
		&& cur_ff.flags[0] == $past(acc_hi_in[0]))
		else $error("flags not loaded from accumulator high byte");

	a_acc_hi_gate: assert property ((op_take && mode64_in && !cur_ff.acc_hi_ok // [RULE14]
		&& (op_in == OP_FLAGS_TO_ACC_HI || op_in == OP_ACC_HI_TO_FLAGS)) |=>
		fault_out && $stable(cur_ff.flags) && $stable(acc_hi_out))
		else $error("accumulator transfer not refused");

	a_push_word_img: assert property (s_take(OP_PUSH_WORD) |=> // [RULE4]
		stk_req_valid_out && stk_req_data_out[63:16] == 48'h0000_0000_0000
		&& stk_req_data_out[15:0] == $past(cur_ff.flags[15:0]))
		else $error("word push image wrong");

	a_push_dword_img: assert property (s_take(OP_PUSH_DWORD) |=> // [RULE5] [RULE16]
		stk_req_data_out[17:16] == 2'h0 && stk_req_data_out[15:0] == $past(cur_ff.flags[15:0])
		&& stk_req_size_out == ($past(mode64_in) ? SZ_QWORD : SZ_DWORD))
		else $error("doubleword push image wrong");

	a_push_hold: assert property ((clk_en_in && cur_ff.st == ST_PUSH && !stk_req_ready_in) |=>
		stk_req_valid_out && $stable(stk_req_data_out))
		else $error("push request dropped while stalled");

	a_pop_guard: assert property (s_pop_end |=> // [RULE19]
		(cur_ff.flags & ~(POP_WORD_MASK | POP_DWORD_EXTRA | IO_PRIV_MASK | IRQ_EN_MASK))
		== ($past(cur_ff.flags) & ~(POP_WORD_MASK | POP_DWORD_EXTRA | IO_PRIV_MASK
		| IRQ_EN_MASK)) && done_out)
		else $error("pop changed a protected flag");

	a_pop_io_priv: assert property (s_pop_end and priv_level_in != 2'h0 |=> // [RULE7]
		cur_ff.flags[13:12] == $past(cur_ff.flags[13:12]))
		else $error("I/O privilege changed above level 0");

	a_pop_irq_en: assert property (s_pop_end // [RULE8]
		and cur_ff.flags[13:12] < priv_level_in |=> cur_ff.flags[9] == $past(cur_ff.flags[9]))
		else $error("interrupt enable changed without privilege");

	a_pop_dword: assert property (s_pop_end and cur_ff.stk_size != SZ_WORD |=> // [RULE9]
		cur_ff.flags[18] == $past(stk_rsp_data_in[18])
		&& cur_ff.flags[21] == $past(stk_rsp_data_in[21]))
		else $error("doubleword pop did not load upper bits");

	a_irq_mask: assert property (maskable_irq_pin_in |-> // [RULE11]
		irq_service_out == cur_ff.flags[BIT_IRQ_EN])
		else $error("interrupt service does not follow enable");

	a_irq_set_ok: assert property (s_take(OP_SET_IRQ_EN) and irq_ok |=> // [RULE12]
		cur_ff.flags[BIT_IRQ_EN] && !fault_out && done_out)
		else $error("set interrupt enable failed");

	a_irq_refuse: assert property ((op_take && !irq_ok // [RULE13]
		&& (op_in == OP_SET_IRQ_EN || op_in == OP_CLR_IRQ_EN)) |=>
		fault_out && $stable(cur_ff.flags[9]))
		else $error("interrupt enable change not refused");

	a_dir_write: assert property (s_take(OP_SET_DIR) |=> index_step_down_out) // [RULE18]
		else $error("direction flag not set");

	a_pop_finish: assert property (s_pop_end |=> cur_ff.st == ST_IDLE && done_out)
		else $error("pop did not finish");

endmodule : fxu_top

// [verif/fxu_stack_model.sv]
`timescale 1ns/10ps
module fxu_stack_model
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic slow_in,
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [1:0] req_size_in,
	input wire logic [63:0] req_data_in,
	input wire logic [63:0] pop_data_in,
	output logic req_ready_out,
	output logic rsp_valid_out,
	output logic [63:0] rsp_data_out,
	output logic [63:0] last_data_out,
	output logic [1:0] last_size_out
);
	logic [1:0] wait_ff;
	logic [1:0] delay_ff;
	logic pend_ff;
	logic answer;
	// Slow mode stalls each request and each answer by three cycles
	assign req_ready_out = req_valid_in && (wait_ff == (slow_in ? 2'h3 : 2'h0));
	assign answer = pend_ff && (delay_ff == 2'h0);
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wait_ff <= 2'h0;
			delay_ff <= 2'h0;
			pend_ff <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_data_out <= 64'h0;
			last_data_out <= 64'h0;
			last_size_out <= 2'h3;
		end
		else
		begin
			wait_ff <= (req_valid_in && !req_ready_out) ? wait_ff + 2'h1 : 2'h0;
			rsp_valid_out <= answer;
			// Data line toggles outside the answer cycle
			rsp_data_out <= answer ? pop_data_in : ~rsp_data_out;
			if (pend_ff && !answer)
				delay_ff <= delay_ff - 2'h1;
			if (answer)
				pend_ff <= 1'b0;
			if (req_ready_out && req_write_in)
			begin
				last_data_out <= req_data_in;
				last_size_out <= req_size_in;
			end
			if (req_ready_out && !req_write_in)
			begin
				pend_ff <= 1'b1;
				delay_ff <= slow_in ? 2'h3 : 2'h0;
			end
		end
	end
endmodule : fxu_stack_model

// [verif/flags_transfer_unit_tb.sv]
`timescale 1ns/10ps
module flags_transfer_unit_tb
	import fxu_pkg::*;
;
	logic clock_in, rst_in, op_valid_in, op_ready_out, mode64_in, prot_mode_in;
	logic done_out, fault_out, irq_pin, irq_service_out, step_down, slow;
	logic sq_valid, sq_ready, sq_write, rs_valid;
	logic [1:0] priv_level_in, sq_size, last_size;
	logic [7:0] acc_hi_in, acc_hi_out;
	logic [63:0] sq_data, rs_data, flags_out, pop_data, last_data;
	fxu_op_e op_in;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, rs;
	logic clk_en;
	int errors;
	int samples_checked;

	fxu_top #(.ACC_HI_64_RESET(1'b1)) dut (.clock_in(clock_in), .rst_in(rst_in), .clk_en_in(clk_en),
		.op_valid_in(op_valid_in), .op_ready_out(op_ready_out), .op_in(op_in),
		.mode64_in(mode64_in), .prot_mode_in(prot_mode_in), .priv_level_in(priv_level_in),
		.acc_hi_in(acc_hi_in), .acc_hi_out(acc_hi_out), .done_out(done_out), .fault_out(fault_out),
		.stk_req_valid_out(sq_valid), .stk_req_ready_in(sq_ready), .stk_req_write_out(sq_write),
		.stk_req_size_out(sq_size), .stk_req_data_out(sq_data), .stk_rsp_valid_in(rs_valid),
		.stk_rsp_data_in(rs_data), .flags_out(flags_out), .maskable_irq_pin_in(irq_pin),
		.irq_service_out(irq_service_out), .index_step_down_out(step_down),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	fxu_stack_model stack (.clock_in(clock_in), .rst_in(rst_in), .slow_in(slow),
		.req_valid_in(sq_valid), .req_write_in(sq_write), .req_size_in(sq_size),
		.req_data_in(sq_data), .pop_data_in(pop_data), .req_ready_out(sq_ready),
		.rsp_valid_out(rs_valid), .rsp_data_out(rs_data), .last_data_out(last_data),
		.last_size_out(last_size));

	always #5 clock_in = ~clock_in;

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	// One operation: hold the request until taken, then wait for completion
	task automatic run_op(input fxu_op_e op, input logic [7:0] acc, input logic [1:0] priv,
		input logic prot, input logic m64, input logic flt);
		@(posedge clock_in);
		op_in <= op;
		acc_hi_in <= acc;
		priv_level_in <= priv;
		prot_mode_in <= prot;
		mode64_in <= m64;
		op_valid_in <= 1'b1;
		@(negedge clock_in);
		while (op_ready_out !== 1'b1) @(negedge clock_in);
		@(posedge clock_in);
		op_valid_in <= 1'b0;
		@(negedge clock_in);
		while (done_out !== 1'b1) @(negedge clock_in);
		check("fault", 64'(fault_out), 64'(flt));
	endtask : run_op

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clock_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(negedge clock_in);
		while (!(awready === 1'b1 && wready === 1'b1)) @(negedge clock_in);
		@(posedge clock_in);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(negedge clock_in);
		while (bvalid !== 1'b1) @(negedge clock_in);
		r = bresp;
		@(posedge clock_in);
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(negedge clock_in);
		while (arready !== 1'b1) @(negedge clock_in);
		@(posedge clock_in);
		arvalid <= 1'b0;
		@(negedge clock_in);
		while (rvalid !== 1'b1) @(negedge clock_in);
		d = rdata;
		r = rresp;
		@(posedge clock_in);
		rready <= 1'b0;
	endtask : axi_rd

	initial
	begin
		repeat (6000) @(posedge clock_in);
		errors++;
		report_and_stop();
	end

	initial
	begin
		{clock_in, op_valid_in, mode64_in, prot_mode_in, irq_pin, slow} = 6'h00;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, acc_hi_in, priv_level_in, pop_data} = 0;
		op_in = OP_SET_DIR;
		clk_en = 1'b1;
		rst_in = 1'b1;
		errors = 0;
		samples_checked = 0;
		repeat (16) @(posedge clock_in);
		check("flags_rst", flags_out, 64'h2);
		rst_in <= 1'b0;
		run_op(OP_ACC_HI_TO_FLAGS, 8'hFF, 2'h0, 1'b0, 1'b0, 1'b0);
		check("flags", flags_out, 64'hD7);
		run_op(OP_FLAGS_TO_ACC_HI, 8'h00, 2'h0, 1'b0, 1'b0, 1'b0);
		check("acc_hi", 64'(acc_hi_out & 8'hD5), 64'hD5);
		check("flags", flags_out, 64'hD7);
		run_op(OP_ACC_HI_TO_FLAGS, 8'h2A, 2'h0, 1'b0, 1'b0, 1'b0);
		check("flags", flags_out, 64'h2);
		run_op(OP_SET_DIR, 8'h00, 2'h0, 1'b0, 1'b0, 1'b0);
		check("step_down", 64'(step_down), 64'h1);
		run_op(OP_CLR_DIR, 8'h00, 2'h0, 1'b0, 1'b0, 1'b0);
		check("step_down", 64'(step_down), 64'h0);
		@(posedge clock_in);
		irq_pin <= 1'b1;
		run_op(OP_SET_IRQ_EN, 8'h00, 2'h0, 1'b0, 1'b0, 1'b0);
		check("flags", flags_out, 64'h202);
		check("irq", 64'(irq_service_out), 64'h1);
		run_op(OP_CLR_IRQ_EN, 8'h00, 2'h0, 1'b0, 1'b0, 1'b0);
		check("irq", 64'(irq_service_out), 64'h0);
		run_op(OP_SET_IRQ_EN, 8'h00, 2'h3, 1'b1, 1'b0, 1'b1);
		check("flags", flags_out, 64'h2);
		slow = 1'b1;
		pop_data = 64'hFFFF;
		run_op(OP_POP_WORD, 8'h00, 2'h0, 1'b1, 1'b0, 1'b0);
		check("flags", flags_out, 64'h3FD7);
		run_op(OP_PUSH_WORD, 8'h00, 2'h0, 1'b1, 1'b1, 1'b0);
		check("push", {62'h0, last_size} << 32 | last_data, 64'h3FD7);
		run_op(OP_PUSH_DWORD, 8'h00, 2'h0, 1'b1, 1'b0, 1'b0);
		check("push", {62'h0, last_size} << 32 | last_data, 64'h1_0000_3FD7);
		run_op(OP_PUSH_DWORD, 8'h00, 2'h0, 1'b1, 1'b1, 1'b0);
		check("push", {62'h0, last_size} << 32 | last_data, 64'h2_0000_3FD7);
		slow = 1'b0;
		pop_data = 64'hFFFF_FFFF_FFFF_0000;
		run_op(OP_POP_WORD, 8'h00, 2'h3, 1'b1, 1'b0, 1'b0);
		check("flags", flags_out, 64'h3002);
		pop_data = 64'h0;
		run_op(OP_POP_WORD, 8'h00, 2'h0, 1'b1, 1'b0, 1'b0);
		check("flags", flags_out, 64'h2);
		pop_data = 64'hFFFF;
		run_op(OP_POP_WORD, 8'h00, 2'h3, 1'b1, 1'b1, 1'b0);
		check("flags", flags_out, 64'hDD7);
		pop_data = 64'hFFFF_FFFF_FFFF_FFFF;
		run_op(OP_POP_DWORD, 8'h00, 2'h0, 1'b1, 1'b1, 1'b0);
		check("flags", flags_out, 64'h24_3FD7);
		pop_data = 64'h0;
		run_op(OP_POP_DWORD, 8'h00, 2'h3, 1'b1, 1'b0, 1'b0);
		check("flags", flags_out, 64'h3002);
		axi_rd(REG_CTRL, rd, rs);
		check("ctrl", 64'({rs, rd}), 64'({AXI_OKAY, 32'h1}));
		axi_rd(REG_FLAGS, rd, rs);
		check("flags_reg", 64'(rd), 64'h3002);
		axi_wr(REG_CTRL, 32'h0, rs);
		check("bresp", 64'(rs), 64'(AXI_OKAY));
		run_op(OP_ACC_HI_TO_FLAGS, 8'hFF, 2'h0, 1'b0, 1'b1, 1'b1);
		check("flags", flags_out, 64'h3002);
		axi_rd(REG_STATUS, rd, rs);
		check("status", 64'(rd), 64'h2);
		axi_wr(REG_STATUS, 32'h2, rs);
		axi_rd(REG_STATUS, rd, rs);
		check("status", 64'(rd), 64'h0);
		run_op(OP_ACC_HI_TO_FLAGS, 8'hFF, 2'h0, 1'b0, 1'b0, 1'b0);
		check("flags", flags_out, 64'h30D7);
		axi_wr(REG_CTRL, 32'h1, rs);
		check("bresp", 64'(rs), 64'(AXI_OKAY));
		run_op(OP_ACC_HI_TO_FLAGS, 8'h00, 2'h0, 1'b0, 1'b1, 1'b0);
		check("flags", flags_out, 64'h3002);
		axi_rd(8'h40, rd, rs);
		check("rresp", 64'(rs), 64'(AXI_SLVERR));
		axi_wr(8'h40, 32'h1, rs);
		check("bresp", 64'(rs), 64'(AXI_SLVERR));
		@(posedge clock_in);
		clk_en <= 1'b0;
		op_in <= OP_SET_DIR;
		op_valid_in <= 1'b1;
		repeat (3) @(negedge clock_in);
		check("frozen", 64'({op_ready_out, step_down}), 64'h0);
		@(posedge clock_in);
		clk_en <= 1'b1;
		op_valid_in <= 1'b0;
		@(negedge clock_in);
		check("frozen", 64'(step_down), 64'h0);
		report_and_stop();
	end
endmodule : flags_transfer_unit_tb
